// file: design/rpb_regs.svh
// Register map of the bridge control
`ifndef RPB_REGS_SVH
`define RPB_REGS_SVH

// Register byte offsets
`define RPB_BRIDGE_CONTROL_OFF   8'h3E
`define RPB_DMA_PRESENT_OFF      8'h44
`define RPB_PORT_CONTROL_OFF     8'h48
// Dword that holds the bridge control register in its upper half
`define RPB_BRIDGE_CONTROL_DW    8'h3C

// bridge_control fields
`define RPB_BC_POISON_REPORT_EN  0
`define RPB_BC_ERR_FORWARD_EN    1
`define RPB_BC_ISA_ALIAS_BLOCK   2
`define RPB_BC_VGA_ROUTE_EN      3
`define RPB_BC_VGA_FULL_DECODE   4
`define RPB_BC_RESET             5'h00

// dma_engine_present_ctrl fields
`define RPB_DP_CFG_ENABLE        0
`define RPB_DP_RESET             1'h0

// port_control fields
`define RPB_PC_MSI_COR_EN        31
`define RPB_PC_MSI_NONFATAL_EN   30
`define RPB_PC_HP_INBAND_EN      29
`define RPB_PC_SLOT_POWER_GOOD   28
`define RPB_PC_TOGGLE_POP        27
`define RPB_PC_COALESCE_HI       25
`define RPB_PC_COALESCE_LO       24
`define RPB_PC_TIMEOUT_CFG_EN    23
`define RPB_PC_TIMEOUT_EN        22
`define RPB_PC_MALFORMED_EN      21
`define RPB_PC_IRQ_WR_UNBLOCK    20
`define RPB_PC_COALESCE_RESET    2'h3

// Decoder address figures
`define RPB_VGA_IO_A_LO          16'h03B0
`define RPB_VGA_IO_A_HI          16'h03BB
`define RPB_VGA_IO_B_LO          16'h03C0
`define RPB_VGA_IO_B_HI          16'h03DF
`define RPB_VGA_MEM_LO           32'h000A0000
`define RPB_VGA_MEM_HI           32'h000BFFFF
`define RPB_IRQ_RANGE            12'hFEE
`define RPB_DMA_DEVICE           5'h08

// Completion timeout in microseconds and in cycles
`define RPB_CLK_PERIOD_NS        100
`define RPB_CPL_TIMEOUT_US       50000
`define RPB_CPL_TIMEOUT_CYCLES   ((`RPB_CPL_TIMEOUT_US * 1000) / `RPB_CLK_PERIOD_NS)

`endif

// file: design/rpb_pkg.sv
// Types of the root port bridge control
package rpb_pkg;

   typedef enum logic [1:0] {
      RPB_ROUTE_NONE,
      RPB_ROUTE_DOWNSTREAM,
      RPB_ROUTE_SOUTHBRIDGE
   } rpb_route_e;

   typedef struct packed {
      logic        valid;
      logic        is_io;
      logic        is_mem;
      logic [31:0] addr;
   } rpb_cpu_req_s;

   typedef struct packed {
      logic       valid;
      logic [1:0] kind;     // 0 correctable, 1 non-fatal, 2 fatal
   } rpb_err_msg_s;

   typedef struct packed {
      logic       valid;
      logic       from_sideband;  // Test port or SMBus
      logic [4:0] device;
      logic [2:0] func;
   } rpb_dma_req_s;

   typedef struct packed {
      logic       valid;
      logic       hdr_4dw;
      logic       is_mem;
      logic       is_io;
      logic       is_cfg;
      logic [7:0] addr_hi;
      logic [9:0] length;
      logic [3:0] first_be;
      logic [3:0] last_be;
      logic [2:0] tc;
      logic [1:0] attr;
      logic       is_crs_cpl;
      logic       req_was_cfg;
   } rpb_tlp_s;

endpackage

// file: design/rpb_bridge_ctrl.sv
// Root port virtual bridge control: registers, address routing, error and TLP checks
// Functional notes
// - VGA full decode compares 16 address bits, else 10 bits with 1 KB aliases.
// - Full-decode choice matters only while VGA routing is enabled.
// - VGA routing enabled: claim VGA I/O and memory ranges, route downstream.
// - ISA alias block: last 768 bytes of each 1 KB go to southbridge link.
// - ISA alias block clear: whole I/O window goes downstream.
// - Error-forward enable gates correctable, non-fatal and fatal messages upstream.
// - Received system error flag records regardless of error-forward enable.
// - Poison-report enable decides whether poisoned TLPs are reported.
// - Write-once DMA config enable resets 0; while 0 requests to DMA device functions 0 and 1 abort.
// - Test port and SMBus reach DMA engine regardless of enable.
// - Bit 31 enables MSI for correctable errors.
// - Bit 30 enables MSI for non-fatal errors.
// - Bit 29 enables in-band hot-plug messages, resets 0.
// - Bit 28 reflects power-good input; reads 0 on southbridge link port.
// - Coalescing policy resets 3: none, free entries, prefetches, minimum.
// - Configuration requests time out only when bits 23 and 22 both set.
// - Both timeout enables clear: wait for completions forever.
// - Malformed check flags 4DW low address, byte enable and I/O/config faults.
// - Malformed check flags retry completion for non-configuration request.
// - Bit 20 clear blocks memory writes to the interrupt range.
`timescale 1ns/1ns
`default_nettype none
`include "rpb_regs.svh"

module rpb_bridge_ctrl
   import rpb_pkg::*;
#(
   parameter bit          IS_SB_LINK     = 1'b0,
   parameter int unsigned TIMEOUT_CYCLES = `RPB_CPL_TIMEOUT_CYCLES
) (
   input  wire logic         I_CLK,
   input  wire logic         I_RST,
   input  wire logic         i_cfg_wr,
   input  wire logic         i_cfg_rd,
   input  wire logic [7:0]   i_cfg_addr,
   input  wire logic [3:0]   i_cfg_be,
   input  wire logic [31:0]  i_cfg_wdata,
   output logic     [31:0]   o_cfg_rdata,
   output logic              o_cfg_rvalid,
   input  wire rpb_cpu_req_s i_cpu_req,
   input  wire logic [15:0]  i_io_window_base,
   input  wire logic [15:0]  i_io_window_limit,
   output var rpb_route_e    o_route,
   output logic              o_route_valid,
   input  wire rpb_err_msg_s i_err_msg,
   input  wire logic         i_sec_sys_err_clr,
   input  wire logic         i_poison_rx,
   output var rpb_err_msg_s  o_err_fwd,
   output logic              o_sec_sys_err_seen,
   output logic              o_poison_report,
   input  wire rpb_dma_req_s i_dma_req,
   output logic              o_dma_grant,
   output logic              o_dma_abort,
   input  wire logic         i_cor_err,
   input  wire logic         i_nonfatal_err,
   output logic              o_msi_req,
   input  wire logic         i_hp_msg_req,
   output logic              o_hp_msg_send,
   input  wire logic         i_slot_power_good,
   input  wire logic [7:0]   i_coalesce_hint,
   input  wire logic [7:0]   i_free_completion_entries,
   input  wire logic [7:0]   i_pending_prefetches,
   output logic     [7:0]    o_coalesce_limit,
   input  wire logic         i_cpl_pending,
   input  wire logic         i_pending_is_cfg,
   output logic              o_cpl_timeout,
   input  wire rpb_tlp_s     i_tlp,
   output logic              o_malformed,
   input  wire logic         i_mem_wr_valid,
   input  wire logic [31:0]  i_mem_wr_addr,
   output logic              o_irq_wr_block
);

   logic [4:0]  bridge_control_q;
   logic        dma_cfg_en_q;
   logic        dma_locked_q;
   logic [2:0]  pc_msi_hp_q;    // 31:29
   logic        toggle_pop_q;
   logic [1:0]  coalesce_mode_q;
   logic [3:0]  pc_low_q;       // 23:20
   logic        pg_s1_q, pg_s2_q, pg_s3_q, pg_q;

   logic bc_hit, dp_hit, pc_hit;
   assign bc_hit = (i_cfg_addr == `RPB_BRIDGE_CONTROL_DW);
   assign dp_hit = (i_cfg_addr == `RPB_DMA_PRESENT_OFF);
   assign pc_hit = (i_cfg_addr == `RPB_PORT_CONTROL_OFF);

   // Bridge control sits in lanes 2 and 3 of its dword
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         bridge_control_q <= `RPB_BC_RESET;
      end else if (i_cfg_wr && bc_hit && i_cfg_be[2]) begin
         bridge_control_q <= i_cfg_wdata[20:16];
      end
   end

   // Lock follows the first write after reset, whatever value it carried
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         dma_cfg_en_q <= `RPB_DP_RESET;
         dma_locked_q <= 1'b0;
      end else if (i_cfg_wr && dp_hit && i_cfg_be[0] && !dma_locked_q) begin
         dma_cfg_en_q <= i_cfg_wdata[`RPB_DP_CFG_ENABLE];
         dma_locked_q <= 1'b1;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         pc_msi_hp_q     <= 3'h0;
         toggle_pop_q    <= 1'b0;
         coalesce_mode_q <= `RPB_PC_COALESCE_RESET;
         pc_low_q        <= 4'h0;
      end else if (i_cfg_wr && pc_hit) begin
         if (i_cfg_be[3]) begin
            pc_msi_hp_q     <= i_cfg_wdata[31:29];
            toggle_pop_q    <= i_cfg_wdata[`RPB_PC_TOGGLE_POP];
            coalesce_mode_q <= i_cfg_wdata[`RPB_PC_COALESCE_HI:`RPB_PC_COALESCE_LO];
         end
         if (i_cfg_be[2]) begin
            pc_low_q <= i_cfg_wdata[23:20];
         end
      end
   end

   logic msi_cor_en, msi_nf_en, hp_inband_en;
   logic to_cfg_en, to_en, malformed_en, irq_unblock;
   assign msi_cor_en   = pc_msi_hp_q[2];
   assign msi_nf_en    = pc_msi_hp_q[1];
   assign hp_inband_en = pc_msi_hp_q[0];
   assign to_cfg_en    = pc_low_q[3];
   assign to_en        = pc_low_q[2];
   assign malformed_en = pc_low_q[1];
   assign irq_unblock  = pc_low_q[0];

   // Power-good pin: three stages, change taken once stages two and three agree
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         pg_s1_q <= 1'b0;
         pg_s2_q <= 1'b0;
         pg_s3_q <= 1'b0;
         pg_q    <= 1'b0;
      end else begin
         pg_s1_q <= i_slot_power_good;
         pg_s2_q <= pg_s1_q;
         pg_s3_q <= pg_s2_q;
         if (pg_s2_q == pg_s3_q) begin
            pg_q <= pg_s3_q & ~IS_SB_LINK;
         end
      end
   end

   // Read mux; reserved and unmapped bits read zero
   logic [31:0] rdata_d;
   always_comb begin
      rdata_d = 32'h00000000;
      if (bc_hit) begin
         rdata_d[20:16] = bridge_control_q;
      end else if (dp_hit) begin
         rdata_d[`RPB_DP_CFG_ENABLE] = dma_cfg_en_q;
      end else if (pc_hit) begin
         rdata_d[31:29]                   = pc_msi_hp_q;
         rdata_d[`RPB_PC_SLOT_POWER_GOOD] = pg_q;
         rdata_d[`RPB_PC_TOGGLE_POP]      = toggle_pop_q;
         rdata_d[25:24]                   = coalesce_mode_q;
         rdata_d[23:20]                   = pc_low_q;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         o_cfg_rdata  <= 32'h00000000;
         o_cfg_rvalid <= 1'b0;
      end else begin
         o_cfg_rvalid <= i_cfg_rd;
         o_cfg_rdata  <= i_cfg_rd ? rdata_d : 32'h00000000;
      end
   end

   logic [15:0] io_addr, vga_cmp;
   logic        vga_io_hit, vga_mem_hit, in_io_window, isa_alias;
   rpb_route_e  route_d;
   assign io_addr = i_cpu_req.addr[15:0];
   // Short decode drops bits 15:10, so the ranges alias every 1 KB
   assign vga_cmp = bridge_control_q[`RPB_BC_VGA_FULL_DECODE] ? io_addr
                                                     : {6'h00, io_addr[9:0]};
   assign vga_io_hit = i_cpu_req.is_io && (i_cpu_req.addr[31:16] == 16'h0000
                       || !bridge_control_q[`RPB_BC_VGA_FULL_DECODE])
                       && ((vga_cmp >= `RPB_VGA_IO_A_LO && vga_cmp <= `RPB_VGA_IO_A_HI)
                       || (vga_cmp >= `RPB_VGA_IO_B_LO && vga_cmp <= `RPB_VGA_IO_B_HI));
   assign vga_mem_hit = i_cpu_req.is_mem && i_cpu_req.addr >= `RPB_VGA_MEM_LO
                        && i_cpu_req.addr <= `RPB_VGA_MEM_HI;
   assign in_io_window = i_cpu_req.is_io && i_cpu_req.addr[31:16] == 16'h0000
                         && io_addr >= i_io_window_base && io_addr <= i_io_window_limit;
   assign isa_alias = io_addr[9:8] != 2'h0;

   always_comb begin
      route_d = RPB_ROUTE_NONE;
      // VGA decode, full or short, counts only while routing is on
      if (bridge_control_q[`RPB_BC_VGA_ROUTE_EN] && (vga_io_hit || vga_mem_hit)) begin
         route_d = RPB_ROUTE_DOWNSTREAM;
      end else if (in_io_window) begin
         if (bridge_control_q[`RPB_BC_ISA_ALIAS_BLOCK] && isa_alias) begin
            route_d = RPB_ROUTE_SOUTHBRIDGE;
         end else begin
            route_d = RPB_ROUTE_DOWNSTREAM;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         o_route       <= RPB_ROUTE_NONE;
         o_route_valid <= 1'b0;
      end else begin
         o_route_valid <= i_cpu_req.valid;
         o_route       <= i_cpu_req.valid ? route_d : RPB_ROUTE_NONE;
      end
   end

   logic serr_rx;
   assign serr_rx = i_err_msg.valid && i_err_msg.kind != 2'h0;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         o_err_fwd          <= '0;
         o_sec_sys_err_seen <= 1'b0;
         o_poison_report    <= 1'b0;
      end else begin
         o_err_fwd.valid <= i_err_msg.valid && bridge_control_q[`RPB_BC_ERR_FORWARD_EN];
         o_err_fwd.kind  <= i_err_msg.kind;
         // Set wins over a clear in the same cycle
         if (serr_rx) begin
            o_sec_sys_err_seen <= 1'b1;
         end else if (i_sec_sys_err_clr) begin
            o_sec_sys_err_seen <= 1'b0;
         end
         o_poison_report <= i_poison_rx && bridge_control_q[`RPB_BC_POISON_REPORT_EN];
      end
   end

   // DMA engine access; functions 0 and 1 of its device are gated
   logic dma_target;
   assign dma_target = i_dma_req.device == `RPB_DMA_DEVICE && i_dma_req.func[2:1] == 2'h0;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         o_dma_grant <= 1'b0;
         o_dma_abort <= 1'b0;
      end else begin
         o_dma_grant <= i_dma_req.valid && dma_target
                        && (dma_cfg_en_q || i_dma_req.from_sideband);
         o_dma_abort <= i_dma_req.valid && dma_target
                        && !dma_cfg_en_q && !i_dma_req.from_sideband;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         o_msi_req     <= 1'b0;
         o_hp_msg_send <= 1'b0;
      end else begin
         o_msi_req <= (i_cor_err && msi_cor_en)
                      || (i_nonfatal_err && msi_nf_en);
         o_hp_msg_send <= i_hp_msg_req && hp_inband_en;
      end
   end

   logic [7:0] lim_free, lim_pf, limit_d;
   assign lim_free = i_coalesce_hint < i_free_completion_entries ? i_coalesce_hint
                                                                 : i_free_completion_entries;
   assign lim_pf   = i_coalesce_hint < i_pending_prefetches ? i_coalesce_hint
                                                            : i_pending_prefetches;
   always_comb begin
      case (coalesce_mode_q)
         2'h0:    limit_d = i_coalesce_hint;
         2'h1:    limit_d = lim_free;
         2'h2:    limit_d = lim_pf;
         default: limit_d = lim_free < lim_pf ? lim_free : lim_pf;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         o_coalesce_limit <= 8'h00;
      end else begin
         o_coalesce_limit <= limit_d;
      end
   end

   // Completion timer; restarts when the pending request is served
   logic [31:0] to_cnt_q;
   logic        to_allowed;
   // Configuration needs both enables; with neither, wait forever
   assign to_allowed = i_pending_is_cfg ? (to_cfg_en && to_en) : to_en;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         to_cnt_q      <= 32'h00000000;
         o_cpl_timeout <= 1'b0;
      end else begin
         o_cpl_timeout <= 1'b0;
         if (!i_cpl_pending || !to_allowed) begin
            to_cnt_q <= 32'h00000000;
         end else if (to_cnt_q == TIMEOUT_CYCLES - 1) begin
            to_cnt_q      <= 32'h00000000;
            o_cpl_timeout <= 1'b1;
         end else begin
            to_cnt_q <= to_cnt_q + 32'h00000001;
         end
      end
   end

   logic bad_4dw, bad_be, bad_iocfg, bad_crs;
   assign bad_4dw  = i_tlp.hdr_4dw && i_tlp.is_mem && i_tlp.addr_hi == 8'h00;
   assign bad_be   = (i_tlp.is_mem || i_tlp.is_io || i_tlp.is_cfg)
                     && ((i_tlp.length > 10'h001
                          && (i_tlp.first_be == 4'h0 || i_tlp.last_be == 4'h0))
                         || (i_tlp.length == 10'h001 && i_tlp.last_be != 4'h0));
   assign bad_iocfg = (i_tlp.is_io || i_tlp.is_cfg)
                      && (i_tlp.tc != 3'h0 || i_tlp.attr != 2'h0 || i_tlp.length != 10'h001);
   assign bad_crs  = i_tlp.is_crs_cpl && !i_tlp.req_was_cfg;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         o_malformed <= 1'b0;
      end else begin
         o_malformed <= i_tlp.valid && malformed_en
                        && (bad_4dw || bad_be || bad_iocfg
                            || bad_crs);
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         o_irq_wr_block <= 1'b0;
      end else begin
         o_irq_wr_block <= i_mem_wr_valid && !irq_unblock
                           && i_mem_wr_addr[31:20] == `RPB_IRQ_RANGE;
      end
   end

endmodule
`default_nettype wire

// file: sim/rpb_bridge_ctrl_asserts.sv
// Bound port checks of the bridge control block
`timescale 1ns/1ns
`default_nettype none
module rpb_bridge_ctrl_asserts
   import rpb_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = 20
) (
   input wire logic         I_CLK,
   input wire logic         I_RST,
   input wire rpb_cpu_req_s i_cpu_req,
   input wire logic         o_route_valid,
   input wire rpb_err_msg_s i_err_msg,
   input wire rpb_err_msg_s o_err_fwd,
   input wire logic         o_sec_sys_err_seen,
   input wire rpb_dma_req_s i_dma_req,
   input wire logic         o_dma_grant,
   input wire logic         o_dma_abort,
   input wire logic         i_cor_err,
   input wire logic         i_nonfatal_err,
   input wire logic         o_msi_req,
   input wire logic         i_hp_msg_req,
   input wire logic         o_hp_msg_send,
   input wire logic         i_cpl_pending,
   input wire logic         o_cpl_timeout,
   input wire logic         i_mem_wr_valid,
   input wire logic [31:0]  i_mem_wr_addr,
   input wire logic         o_irq_wr_block
);
   int unsigned pend_q;
   logic        dma_hit;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   assign dma_hit = i_dma_req.valid && i_dma_req.device == 5'h08 && i_dma_req.func < 3'h2;
   // Only a floor: enables are not visible here
   always_ff @(posedge I_CLK) begin
      if (I_RST || !i_cpl_pending) begin
         pend_q <= 0;
      end else begin
         pend_q <= pend_q + 1;
      end
   end
   route_answer_a: assert property (i_cpu_req.valid |=> o_route_valid)
      else $error("route answer missing");
   err_fwd_cause_a: assert property (o_err_fwd.valid |-> $past(i_err_msg.valid)
      && o_err_fwd.kind == $past(i_err_msg.kind)) else $error("forward without message");
   sys_err_set_a: assert property (i_err_msg.valid && i_err_msg.kind != 2'h0
      |=> o_sec_sys_err_seen) else $error("system error not recorded");
   dma_sideband_a: assert property (dma_hit && i_dma_req.from_sideband
      |=> o_dma_grant && !o_dma_abort) else $error("sideband access refused");
   dma_one_answer_a: assert property (dma_hit |=> o_dma_grant != o_dma_abort)
      else $error("dma answer not exclusive");
   msi_cause_a: assert property (o_msi_req |-> $past(i_cor_err) || $past(i_nonfatal_err))
      else $error("msi without error");
   hp_msg_cause_a: assert property (o_hp_msg_send |-> $past(i_hp_msg_req))
      else $error("hot-plug message without request");
   timeout_floor_a: assert property (o_cpl_timeout |-> pend_q >= TIMEOUT_CYCLES - 1)
      else $error("timeout too early");
   irq_block_cause_a: assert property (o_irq_wr_block |-> $past(i_mem_wr_valid)
      && $past(i_mem_wr_addr[31:20]) == 12'hFEE) else $error("block outside range");
endmodule

bind rpb_bridge_ctrl rpb_bridge_ctrl_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_asserts (.*);
`default_nettype wire

// file: sim/rpb_link_model.sv
// Downstream link partner model
`timescale 1ns/1ns
`default_nettype none
module rpb_link_model
   import rpb_pkg::*;
(
   input  wire logic    i_clk,
   output var rpb_err_msg_s o_err_msg,
   output logic         o_poison_rx,
   output var rpb_tlp_s o_tlp,
   output logic         o_cpl_pending,
   output logic         o_pending_is_cfg
);
   initial begin
      o_err_msg = '0;
      o_poison_rx = 1'b0;
      o_tlp = '0;
      o_cpl_pending = 1'b0;
      o_pending_is_cfg = 1'b0;
   end
   // Idle fields are inverted so stale values never look right
   task automatic send_err(input logic [1:0] kind);
      @(negedge i_clk);
      o_err_msg = {1'b1, kind};
      @(negedge i_clk);
      o_err_msg = {1'b0, ~kind};
   endtask
   task automatic send_poison();
      @(negedge i_clk);
      o_poison_rx = 1'b1;
      @(negedge i_clk);
      o_poison_rx = 1'b0;
   endtask
   task automatic send_tlp(input rpb_tlp_s t);
      @(negedge i_clk);
      o_tlp = t;
      @(negedge i_clk);
      o_tlp = ~t;
      o_tlp.valid = 1'b0;
   endtask
   task automatic hold(input logic on, input logic cfg);
      @(negedge i_clk);
      o_cpl_pending = on;
      o_pending_is_cfg = cfg;
   endtask
endmodule
`default_nettype wire

// file: sim/rpb_bridge_ctrl_tb_top.sv
// Testbench of the root port bridge control block
`timescale 1ns/1ns
`default_nettype none
module rpb_bridge_ctrl_tb_top;
   import rpb_pkg::*;
   localparam int unsigned TMO = 20;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         wr = 1'b0, rd = 1'b0;
   logic [7:0]   addr = 8'h00;
   logic [3:0]   be = 4'h0;
   logic [31:0]  wdata = 32'h0;
   logic [31:0]  rdata, d;
   rpb_cpu_req_s cpu = '0;
   rpb_dma_req_s dma = '0;
   rpb_route_e   route;
   rpb_err_msg_s err_msg, err_fwd;
   rpb_tlp_s     tlp;
   logic         rvalid, route_v, poison, sys_seen, poison_rep, grant, abort, msi;
   logic         hp_send, pend, pend_cfg, tmo, mal, irq_blk;
   logic [7:0]   limit;
   logic         sys_clr = 1'b0, cor = 1'b0, nf = 1'b0, hp = 1'b0, pg = 1'b0, mw = 1'b0;
   logic [31:0]  mw_addr = 32'h0;
   int           n_mismatch = 0;
   int           total_checks = 0;

   always #50 clk = ~clk;

   rpb_bridge_ctrl #(.TIMEOUT_CYCLES(TMO)) dut (
      .I_CLK(clk), .I_RST(rst), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
      .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
      .i_cpu_req(cpu), .i_io_window_base(16'h1000), .i_io_window_limit(16'h1FFF),
      .o_route(route), .o_route_valid(route_v), .i_err_msg(err_msg),
      .i_sec_sys_err_clr(sys_clr), .i_poison_rx(poison), .o_err_fwd(err_fwd),
      .o_sec_sys_err_seen(sys_seen), .o_poison_report(poison_rep), .i_dma_req(dma),
      .o_dma_grant(grant), .o_dma_abort(abort), .i_cor_err(cor), .i_nonfatal_err(nf),
      .o_msi_req(msi), .i_hp_msg_req(hp), .o_hp_msg_send(hp_send),
      .i_slot_power_good(pg), .i_coalesce_hint(8'h40), .i_free_completion_entries(8'h18),
      .i_pending_prefetches(8'h30), .o_coalesce_limit(limit), .i_cpl_pending(pend),
      .i_pending_is_cfg(pend_cfg), .o_cpl_timeout(tmo), .i_tlp(tlp), .o_malformed(mal),
      .i_mem_wr_valid(mw), .i_mem_wr_addr(mw_addr), .o_irq_wr_block(irq_blk)
   );
   rpb_link_model link (
      .i_clk(clk), .o_err_msg(err_msg), .o_poison_rx(poison), .o_tlp(tlp),
      .o_cpl_pending(pend), .o_pending_is_cfg(pend_cfg)
   );

   task automatic results();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cfg_w(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      be = b;
      wdata = v;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic cfg_r(input logic [7:0] a, output logic [31:0] v);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      for (int n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk);
      if (rvalid !== 1'b1) begin
         n_mismatch++;
         results();
      end
      v = rdata;
   endtask
   task automatic set_bc(input logic [4:0] b);
      cfg_w(8'h3C, 4'h4, {11'h0, b, 16'h0});
   endtask
   task automatic ev(input logic [2:0] c);
      @(negedge clk);
      {cor, nf, hp} = c;
      @(negedge clk);
      {cor, nf, hp} = 3'h0;
   endtask
   task automatic rt(input logic [4:0] b, input logic io, input logic [31:0] a,
                     input rpb_route_e e);
      set_bc(b);
      @(negedge clk);
      cpu = {1'b1, io, !io, a};
      @(negedge clk);
      cpu = {3'h0, ~a};
      chk(32'(route_v), 32'h1);
      chk(32'(route), 32'(e));
   endtask
   task automatic dma_chk(input logic sb, input logic [2:0] fn, input logic [1:0] e);
      @(negedge clk);
      dma = {1'b1, sb, 5'h08, fn};
      @(negedge clk);
      dma = '0;
      chk(32'({grant, abort}), 32'(e));
   endtask
   task automatic mwr(input logic [31:0] a, input logic e);
      @(negedge clk);
      mw = 1'b1;
      mw_addr = a;
      @(negedge clk);
      mw = 1'b0;
      chk(32'(irq_blk), 32'(e));
   endtask
   task automatic tmo_chk(input logic [1:0] en, input logic cfg, input int e);
      int n = 0;
      cfg_w(8'h48, 4'hF, {8'h03, en, 22'h0});
      link.hold(1'b1, cfg);
      repeat (2 * TMO + 5) begin
         @(negedge clk);
         if (tmo === 1'b1) n++;
      end
      link.hold(1'b0, cfg);
      chk(n, e);
   endtask

   task automatic t_regs();
      cfg_r(8'h48, d);
      chk(d, 32'h0300_0000);
      cfg_r(8'h44, d);
      chk(d, 32'h0);
      cfg_w(8'h50, 4'hF, 32'hFFFF_FFFF);
      cfg_r(8'h50, d);
      chk(d, 32'h0);
      cfg_w(8'h48, 4'hF, 32'hFFFF_FFFF);
      cfg_r(8'h48, d);
      chk(d, 32'hEBF0_0000);
      cfg_w(8'h3C, 4'hC, 32'hFFFF_FFFF);
      cfg_r(8'h3C, d);
      chk(d, 32'h001F_0000);
   endtask
   task automatic t_dma();
      dma_chk(1'b0, 3'h1, 2'b01);
      dma_chk(1'b1, 3'h0, 2'b10);
      cfg_w(8'h44, 4'h1, 32'h1);
      dma_chk(1'b0, 3'h0, 2'b10);
      cfg_w(8'h44, 4'h1, 32'h0);
      cfg_r(8'h44, d);
      chk(d, 32'h1);
      dma_chk(1'b0, 3'h1, 2'b10);
   endtask
   task automatic t_route();
      rt(5'h08, 1'b1, 32'h07B0, RPB_ROUTE_DOWNSTREAM);
      rt(5'h18, 1'b1, 32'h07B0, RPB_ROUTE_NONE);
      rt(5'h18, 1'b1, 32'h03DF, RPB_ROUTE_DOWNSTREAM);
      rt(5'h18, 1'b1, 32'h03BC, RPB_ROUTE_NONE);
      rt(5'h10, 1'b1, 32'h03B0, RPB_ROUTE_NONE);
      rt(5'h08, 1'b0, 32'h000A_0000, RPB_ROUTE_DOWNSTREAM);
      rt(5'h00, 1'b0, 32'h000B_FFFF, RPB_ROUTE_NONE);
      rt(5'h04, 1'b1, 32'h1100, RPB_ROUTE_SOUTHBRIDGE);
      rt(5'h04, 1'b1, 32'h13FF, RPB_ROUTE_SOUTHBRIDGE);
      rt(5'h04, 1'b1, 32'h1400, RPB_ROUTE_DOWNSTREAM);
      rt(5'h00, 1'b1, 32'h1100, RPB_ROUTE_DOWNSTREAM);
      rt(5'h00, 1'b1, 32'h2000, RPB_ROUTE_NONE);
   endtask
   task automatic t_err();
      for (int f = 0; f < 2; f++) begin
         set_bc({3'h0, f[0], f[0]});
         for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            sys_clr = 1'b1;
            @(negedge clk);
            sys_clr = 1'b0;
            link.send_err(k[1:0]);
            chk(32'(err_fwd.valid), 32'(f));
            if (f == 1) chk(32'(err_fwd.kind), 32'(k));
            chk(32'(sys_seen), 32'(k != 0));
         end
         link.send_poison();
         chk(32'(poison_rep), 32'(f));
      end
   endtask
   task automatic t_msi();
      for (int p = 0; p < 8; p++) begin
         cfg_w(8'h48, 4'hF, {p[2:0], 29'h0300_0000});
         ev(3'b100);
         chk(32'(msi), 32'(p[2]));
         ev(3'b010);
         chk(32'(msi), 32'(p[1]));
         ev(3'b001);
         chk(32'(hp_send), 32'(p[0]));
      end
   endtask
   task automatic t_misc();
      logic [6:0] bad = 7'b0110101;
      logic [7:0] lim [4] = '{8'h40, 8'h18, 8'h30, 8'h18};
      rpb_tlp_s   t;
      tmo_chk(2'b01, 1'b0, 2);
      tmo_chk(2'b01, 1'b1, 0);
      tmo_chk(2'b10, 1'b1, 0);
      tmo_chk(2'b11, 1'b1, 2);
      tmo_chk(2'b00, 1'b0, 0);
      for (int e = 0; e < 2; e++) begin
         cfg_w(8'h48, 4'hF, {8'h03, 2'h0, e[0], 21'h0});
         for (int i = 0; i < 7; i++) begin
            t = '0;
            t.valid = 1'b1;
            t.first_be = 4'hF;
            t.is_io = (i == 2 || i == 3);
            t.is_mem = (i < 2 || i == 4);
            t.hdr_4dw = (i < 2);
            t.addr_hi = {7'h0, i == 1};
            t.tc = {2'h0, i == 2};
            t.length = (i == 4) ? 10'h2 : 10'h1;
            t.is_crs_cpl = (i > 4);
            t.req_was_cfg = (i == 6);
            link.send_tlp(t);
            chk(32'(mal), 32'(e[0] && bad[i]));
         end
      end
      cfg_w(8'h48, 4'hF, 32'h0300_0000);
      mwr(32'hFEE0_0010, 1'b1);
      mwr(32'hFED0_0010, 1'b0);
      cfg_w(8'h48, 4'hF, 32'h0310_0000);
      mwr(32'hFEE0_0010, 1'b0);
      for (int m = 0; m < 4; m++) begin
         cfg_w(8'h48, 4'hF, {6'h0, m[1:0], 24'h0});
         repeat (2) @(negedge clk);
         chk(32'(limit), 32'(lim[m]));
      end
      pg = 1'b1;
      repeat (8) @(negedge clk);
      cfg_r(8'h48, d);
      chk(32'(d[28]), 32'h1);
      pg = 1'b0;
      repeat (8) @(negedge clk);
      cfg_r(8'h48, d);
      chk(32'(d[28]), 32'h0);
   endtask

   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_regs();
      t_dma();
      t_route();
      t_err();
      t_msi();
      t_misc();
      results();
   end
endmodule
`default_nettype wire
